//--- rtl/epv_port.v
`timescale 1ns/10ps
`include "epv_map.vh"
// ---------------------------------------------------------------
// Program and verify port
// ---------------------------------------------------------------
module epv_port #(
    parameter AW = 9,
    parameter IW = 23,
    parameter DW = 13
) (
    input wire REF_CLK,                  // System clock
    input wire RESETN,                   // Synchronous reset, low
    input wire RST,                      // Device reset pin, high
    input wire WR_N,                     // Store strobe, low
    input wire RD_N,                     // Fetch strobe, low
    input wire CHIP_SELECT_BURN_PULSE,   // Program pulse pin
    input wire DMA_GRANT_N,              // Grant pin, mode input
    input wire PORT_SELECT_LINE,         // Port select
    input wire SI,                       // Serial input pin
    input wire IRQ,                      // Interrupt pin
    input wire STEP_CLK,                 // Address step pulses
    input wire [7:0] DATA_IN,            // Data port input
    output reg [7:0] DATA_OUT,           // Data port output
    output reg DATA_OE,                  // Data port drive enable
    output reg [1:0] MODE,               // Active mode
    output wire [AW-1:0] IADDR,          // Instruction address
    output wire [AW-1:0] DADDR           // Data address
);
    reg rst_q;
    reg wr_q;
    reg rd_q;
    reg prog_q;
    reg step_q;
    reg [1:0] pend_mode;
    reg pending;
    reg [AW-1:0] iaddr;
    reg [AW-1:0] daddr;
    reg [IW-1:0] iload;
    reg [DW-1:0] dload;
    reg iloaded;
    reg dloaded;
    reg [1:0] mode_cand;
    wire [IW-1:0] irdata;
    wire [DW-1:0] drdata;
    wire rst_fall;
    wire wr_rise;
    wire rd_fall;
    wire prog_rise;
    wire step_rise;
    wire [2:0] slot;
    wire [7:0] rev_in;
    wire iwe;
    wire dwe;

    // Mirror a byte end for end
    function [7:0] rev8;
        input [7:0] b;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                rev8[k] = b[7-k];
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // Edge detection on pins
    // ---------------------------------------------------------------
    // Pins are taken as synchronous, so one stage gives the edge
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            rst_q <= 1'b0;
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            prog_q <= 1'b0;
            step_q <= 1'b0;
        end else begin
            rst_q <= RST;
            wr_q <= WR_N;
            rd_q <= RD_N;
            prog_q <= CHIP_SELECT_BURN_PULSE;
            step_q <= STEP_CLK;
        end
    end

    assign rst_fall = rst_q & ~RST;
    assign wr_rise = ~wr_q & WR_N;
    assign rd_fall = rd_q & ~RD_N;
    assign prog_rise = ~prog_q & CHIP_SELECT_BURN_PULSE;
    assign step_rise = ~step_q & STEP_CLK;
    assign slot = {PORT_SELECT_LINE, SI, IRQ};
    assign rev_in = rev8(DATA_IN);

    // ---------------------------------------------------------------
    // Mode decode at the reset fall
    // ---------------------------------------------------------------
    // All strobes and the grant pin must be low; other patterns
    // leave the device idle rather than guessing a mode.
    always @* begin
        mode_cand = `EPV_MODE_NONE;
        if (!WR_N && !RD_N && !CHIP_SELECT_BURN_PULSE && !DMA_GRANT_N && !IRQ) begin
            case ({PORT_SELECT_LINE, SI})
                2'h0: mode_cand = `EPV_MODE_WRITE;
                2'h1: mode_cand = `EPV_MODE_IREAD;
                2'h2: mode_cand = `EPV_MODE_DREAD;
                default: mode_cand = `EPV_MODE_NONE;
            endcase
        end
    end

    // Mode latches at the fall and acts once the store strobe rises
    always @(posedge REF_CLK) begin
        if (!RESETN || RST) begin
            MODE <= `EPV_MODE_NONE;
            pend_mode <= `EPV_MODE_NONE;
            pending <= 1'b0;
        end else if (rst_fall) begin
            pend_mode <= mode_cand;
            pending <= (mode_cand != `EPV_MODE_NONE);
        end else if (pending && wr_rise) begin
            MODE <= pend_mode;
            pending <= 1'b0;
        end
    end
    // Nothing but RST or RESETN touches MODE once it is set

    // ---------------------------------------------------------------
    // Address counters
    // ---------------------------------------------------------------
    // Counters stop at their end address instead of wrapping, so a
    // stray extra pulse cannot overburn the start location, 000 for instructions or 1ff for data.
    always @(posedge REF_CLK) begin
        if (!RESETN || RST) begin
            iaddr <= `EPV_IADDR_RESET;
            daddr <= `EPV_DADDR_RESET;
        end else if (step_rise) begin
            if ((MODE == `EPV_MODE_WRITE || MODE == `EPV_MODE_IREAD) &&
                iaddr != `EPV_IADDR_END) begin
                iaddr <= iaddr + 1'b1;
            end
            if ((MODE == `EPV_MODE_WRITE || MODE == `EPV_MODE_DREAD) &&
                daddr != `EPV_DADDR_END) begin
                daddr <= daddr - 1'b1;
            end
        end
    end
    assign IADDR = iaddr;
    assign DADDR = daddr;

    // ---------------------------------------------------------------
    // Byte loading and burn
    // ---------------------------------------------------------------
    // Load latches clear after each burn so unloaded bits stay zero
    always @(posedge REF_CLK) begin
        if (!RESETN || RST) begin
            iload <= {IW{1'b0}};
            dload <= {DW{1'b0}};
            iloaded <= 1'b0;
            dloaded <= 1'b0;
        end else if (MODE == `EPV_MODE_WRITE && (prog_rise || rd_fall)) begin
            // A byte strobed in the burn cycle itself survives the clear
            if (prog_rise) begin
                iload <= {IW{1'b0}};
                dload <= {DW{1'b0}};
                iloaded <= 1'b0;
                dloaded <= 1'b0;
            end
            case (rd_fall ? slot : 3'h0)
                `EPV_SLOT_IHIGH: begin
                    iload[22:15] <= rev_in;
                    iloaded <= 1'b1;
                end
                `EPV_SLOT_IMID: begin
                    iload[14:8] <= rev_in[7:1];
                    iloaded <= 1'b1;
                end
                `EPV_SLOT_ILOW: begin
                    iload[7:0] <= rev_in;
                    iloaded <= 1'b1;
                end
                `EPV_SLOT_DLOW: begin
                    dload[4:0] <= DATA_IN[7:3];
                    dloaded <= 1'b1;
                end
                `EPV_SLOT_DHIGH: begin
                    dload[12:5] <= DATA_IN;
                    dloaded <= 1'b1;
                end
                default: begin
                    // Unused slot codes load nothing
                end
            endcase
        end
    end

    // Burn ORs the load into the cell, so bits only ever go high
    assign iwe = (MODE == `EPV_MODE_WRITE) && prog_rise && iloaded;
    assign dwe = (MODE == `EPV_MODE_WRITE) && prog_rise && dloaded;

    epv_mem #(.WIDTH(IW), .AW(AW)) u_imem (
        .clk(REF_CLK),
        .we(iwe),
        .addr(iaddr),
        .wdata(irdata | iload),
        .rdata(irdata)
    );

    epv_mem #(.WIDTH(DW), .AW(AW)) u_dmem (
        .clk(REF_CLK),
        .we(dwe),
        .addr(daddr),
        .wdata(drdata | dload),
        .rdata(drdata)
    );

    // ---------------------------------------------------------------
    // Read data port
    // ---------------------------------------------------------------
    // One cycle from strobe change and two from address change to the
    // port, well inside the access times the programmer expects.
    always @(posedge REF_CLK) begin
        if (!RESETN || RST) begin
            DATA_OUT <= 8'h00;
            DATA_OE <= 1'b0;
        end else if (MODE == `EPV_MODE_IREAD && !RD_N && !PORT_SELECT_LINE) begin
            DATA_OE <= ({SI, IRQ} != 2'h0);
            case ({SI, IRQ})
                2'h1: DATA_OUT <= rev8(irdata[22:15]);
                2'h2: DATA_OUT <= rev8({irdata[14:8], 1'b0});
                2'h3: DATA_OUT <= rev8(irdata[7:0]);
                default: DATA_OUT <= 8'h00;
            endcase
        end else if (MODE == `EPV_MODE_DREAD && slot == 3'h0) begin
            DATA_OE <= 1'b1;
            if (RD_N) begin
                DATA_OUT <= {drdata[4:0], 3'h0};
            end else begin
                DATA_OUT <= drdata[12:5];
            end
        end else begin
            DATA_OUT <= 8'h00;
            DATA_OE <= 1'b0;
        end
    end
endmodule // epv_port

//--- rtl/epv_map.vh
//
// Operation
// - Program pulse only sets bits to one
// - Store strobe low through reset fall enters programming
// - Latched mode holds until the next reset
// - Instruction address counts up per clock pulse
// - Fetch strobe fall captures byte into slot
// - Data address counts down per clock pulse
// - Serial-input high at reset fall selects instruction read
// - Instruction read steps up, bytes chosen by lines
// - Port select high at reset fall selects data read
// - Data read steps down, low then high byte
// - Write slot decode from select, serial, irq lines
// - Read byte decode from strobe and lines
// - Instruction bytes bit reversed, data bytes straight
// - Counters reset to bottom and top, nine bits
//
`ifndef EPV_MAP_VH
`define EPV_MAP_VH

// ---------------------------------------------------------------
// Modes latched at the reset fall
// ---------------------------------------------------------------
`define EPV_MODE_NONE 2'h0
`define EPV_MODE_WRITE 2'h1
`define EPV_MODE_IREAD 2'h2
`define EPV_MODE_DREAD 2'h3

// ---------------------------------------------------------------
// Byte slots {port_select_line, si, irq}
// ---------------------------------------------------------------
`define EPV_SLOT_IHIGH 3'h1
`define EPV_SLOT_IMID 3'h2
`define EPV_SLOT_ILOW 3'h3
`define EPV_SLOT_DLOW 3'h4
`define EPV_SLOT_DHIGH 3'h5

// ---------------------------------------------------------------
// Counter reset and end values
// ---------------------------------------------------------------
`define EPV_IADDR_RESET 9'h000
`define EPV_DADDR_RESET 9'h1ff
`define EPV_IADDR_END 9'h1ff
`define EPV_DADDR_END 9'h000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define EPV_CLK_PERIOD_NS 10
`define EPV_RD_ACCESS_NS 150
`define EPV_RD_ACCESS_CYC (`EPV_RD_ACCESS_NS / `EPV_CLK_PERIOD_NS)

`endif

//--- rtl/epv_mem.v
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Array with registered read port
// ---------------------------------------------------------------
module epv_mem #(
    parameter WIDTH = 23,
    parameter AW = 9
) (
    input wire clk,              // System clock
    input wire we,               // Write enable
    input wire [AW-1:0] addr,    // Address
    input wire [WIDTH-1:0] wdata, // Write data
    output reg [WIDTH-1:0] rdata  // Registered read data
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];
    integer k;

    // Cells start erased, all zero, as an unburnt array does; without
    // this the first read-modify-write would OR into unknown bits.
    initial begin
        for (k = 0; k < (1 << AW); k = k + 1) begin
            mem[k] = {WIDTH{1'b0}};
        end
    end

    // Read is registered; write-through is not needed since the
    // caller waits a cycle after each pulse.
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // epv_mem

//--- verification/epv_port_properties.sv
`timescale 1ns/10ps
// ------------------------------------------------
// Port checks of the program and verify port
// ------------------------------------------------
module epv_port_properties #(
    parameter AW = 9
) (
    input wire REF_CLK, // System clock
    input wire RESETN, // Synchronous reset, low
    input wire RST, // Device reset pin
    input wire RD_N, // Fetch strobe
    input wire PORT_SELECT_LINE, // Port select
    input wire SI, // Serial input pin
    input wire IRQ, // Interrupt pin
    input wire STEP_CLK, // Address step
    input wire [7:0] DATA_OUT, // Data port output
    input wire DATA_OE, // Drive enable
    input wire [1:0] MODE, // Active mode
    input wire [AW-1:0] IADDR, // Instruction address
    input wire [AW-1:0] DADDR // Data address
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // Mode, counters and port behaviour; reads need three settled samples
    property p_hold; (MODE != 2'h0 && !RST) |=> $stable(MODE); endproperty
    a_hold: assert property (p_hold) else $error("mode moved");
    property p_rst; RST |=> IADDR == 9'h000 && DADDR == 9'h1ff && MODE == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_inc; (STEP_CLK && !$past(STEP_CLK) && !RST && MODE[1] != MODE[0]
        && IADDR != 9'h1ff) |=> IADDR == $past(IADDR) + 9'h001; endproperty
    a_inc: assert property (p_inc) else $error("iaddr step");
    property p_dec; (STEP_CLK && !$past(STEP_CLK) && !RST && MODE[0]
        && DADDR != 9'h000) |=> DADDR == $past(DADDR) - 9'h001; endproperty
    a_dec: assert property (p_dec) else $error("daddr step");
    property p_none; (MODE == 2'h0 && !RST) |=> $stable(IADDR) && $stable(DADDR); endproperty
    a_none: assert property (p_none) else $error("idle step");
    property p_ird; (MODE == 2'h2 && !RD_N && !PORT_SELECT_LINE && (SI || IRQ) && !RST)[*3]
        |-> DATA_OE; endproperty
    a_ird: assert property (p_ird) else $error("iread drive");
    property p_drd; (MODE == 2'h3 && RD_N && !(PORT_SELECT_LINE || SI || IRQ) && !RST)[*3]
        |-> DATA_OE && DATA_OUT[2:0] == 3'h0; endproperty
    a_drd: assert property (p_drd) else $error("dread pad");
    property p_wq; (MODE == 2'h1)[*3] |-> !DATA_OE; endproperty
    a_wq: assert property (p_wq) else $error("write drive");
endmodule // epv_port_properties
bind epv_port epv_port_properties #(.AW(AW)) i_props (.REF_CLK, .RESETN, .RST, .RD_N,
    .PORT_SELECT_LINE, .SI, .IRQ, .STEP_CLK, .DATA_OUT, .DATA_OE, .MODE, .IADDR, .DADDR);

//--- verification/epv_prog.sv
`timescale 1ns/10ps
// ------------------------------------------------
// Programmer model, pins change at the falling edge
// ------------------------------------------------
module epv_prog (
    input wire clk, // System clock
    output reg rst, // Device reset pin
    output reg wr_n, // Store strobe
    output reg rd_n, // Fetch strobe
    output reg prog, // Burn pulse
    output reg grant_n, // Grant pin, low unless gnt sets it
    output reg psl, // Port select
    output reg si, // Serial input pin
    output reg irq, // Interrupt pin
    output reg step, // Address step
    output reg [7:0] din // Data port drive
);
    // Burn pulse shortened; the port only acts on its rising edge
    localparam PULSE = 8;
    initial {rst, wr_n, rd_n, prog, grant_n, psl, si, irq, step, din} = 17'h10000;
    task wt(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // Reset, mode pins set, strobe held low across the reset fall
    task enter(input [1:0] sel);
        begin
            wt(1);
            rst = 1'b1;
            {wr_n, rd_n, prog, irq} = 4'h0;
            {psl, si} = sel;
            wt(100);
            rst = 1'b0;
            wt(600);
            wr_n = 1'b1;
            psl = 1'b0;
            wt(4);
        end
    endtask
    // Released port shows the inverse so a stale byte cannot pass
    task load(input [2:0] slot, input [7:0] b);
        begin
            wt(1);
            {psl, si, irq} = slot;
            rd_n = 1'b1;
            din = b;
            wt(2);
            rd_n = 1'b0;
            wt(2);
            rd_n = 1'b1;
            din = ~b;
            wt(2);
        end
    endtask
    // One pulse per loaded location, then the step delay
    task burn;
        begin
            wt(1);
            prog = 1'b1;
            wt(PULSE);
            prog = 1'b0;
            wt(20);
        end
    endtask
    task stp;
        begin
            wt(1);
            step = 1'b1;
            wt(12);
            step = 1'b0;
            wt(12);
        end
    endtask
    // Grant pin level, high makes the next mode entry illegal
    task gnt(input g);
        begin
            wt(1);
            grant_n = g;
        end
    endtask
    task sel(input r, input [2:0] slot);
        begin
            wt(1);
            rd_n = r;
            {psl, si, irq} = slot;
            wt(3);
        end
    endtask
endmodule // epv_prog

//--- verification/epv_port_test.sv
`timescale 1ns/10ps
`include "epv_map.vh"
// ------------------------------------------------
// Bench: program two locations, read them back
// ------------------------------------------------
module epv_port_test;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    wire rst, wr_n, rd_n, prog, gnt_n, psl, si, irq, step, oe;
    wire [7:0] din, dout;
    wire [1:0] mode;
    wire [8:0] iaddr, daddr;
    integer fail_count = 0;
    integer n_compared = 0;
    integer cyc = 0;
    integer i;
    reg [10:0] pair;
    // Slot and byte pairs: location twice, then the next one in mixed order
    function [10:0] ld;
        input integer n;
        begin
            case (n)
                0: ld = 11'h1a5;
                1: ld = 11'h23d;
                2: ld = 11'h381;
                3: ld = 11'h4ff;
                4: ld = 11'h512;
                5: ld = 11'h10f;
                6: ld = 11'h240;
                7: ld = 11'h300;
                8: ld = 11'h400;
                9: ld = 11'h521;
                10: ld = 11'h318;
                11: ld = 11'h1c3;
                12: ld = 11'h267;
                13: ld = 11'h57e;
                default: ld = 11'h44f;
            endcase
        end
    endfunction
    always #5 clk = ~clk;
    epv_prog i_prog (.clk(clk), .rst(rst), .wr_n(wr_n), .rd_n(rd_n), .prog(prog),
        .grant_n(gnt_n), .psl(psl), .si(si), .irq(irq), .step(step), .din(din));
    epv_port i_dut (.REF_CLK(clk), .RESETN(reset_n), .RST(rst), .WR_N(wr_n), .RD_N(rd_n),
        .CHIP_SELECT_BURN_PULSE(prog), .DMA_GRANT_N(gnt_n), .PORT_SELECT_LINE(psl), .SI(si),
        .IRQ(irq), .STEP_CLK(step), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
        .MODE(mode), .IADDR(iaddr), .DADDR(daddr));
    task end_sim;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input string what, input [8:0] exp, input [8:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task rd(input r, input [2:0] slot, input [8:0] exp);
        begin
            i_prog.sel(r, slot);
            chk("port", exp, {oe, dout});
        end
    endtask
    task adr(input [8:0] ei, input [8:0] ed);
        begin
            chk("iaddr", ei, iaddr);
            chk("daddr", ed, daddr);
        end
    endtask
    // Hang guard, about 2.4 times the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count = fail_count + 1;
            end_sim;
        end
    end
    // Main sequence; rereads of the first location are ORs of both burns
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        adr(`EPV_IADDR_RESET, `EPV_DADDR_RESET);
        i_prog.enter(2'h0);
        chk("mode", {7'h0, `EPV_MODE_WRITE}, {7'h0, mode});
        for (i = 0; i < 15; i = i + 1) begin
            pair = ld(i);
            i_prog.load(pair[10:8], pair[7:0]);
            if (i % 5 == 4)
                i_prog.burn;
            if (i == 9)
                i_prog.stp;
        end
        adr(9'h001, 9'h1fe);
        repeat (520) i_prog.stp;
        adr(`EPV_IADDR_END, `EPV_DADDR_END);
        i_prog.enter(2'h1);
        chk("mode", {7'h0, `EPV_MODE_IREAD}, {7'h0, mode});
        adr(9'h000, 9'h1ff);
        rd(1'b0, 3'h1, 9'h1af);
        rd(1'b0, 3'h2, 9'h17d);
        rd(1'b0, 3'h3, 9'h181);
        rd(1'b0, 3'h0, 9'h000);
        i_prog.stp;
        adr(9'h001, 9'h1ff);
        rd(1'b0, 3'h1, 9'h1c3);
        rd(1'b0, 3'h2, 9'h167);
        rd(1'b0, 3'h3, 9'h118);
        i_prog.enter(2'h2);
        chk("mode", {7'h0, `EPV_MODE_DREAD}, {7'h0, mode});
        rd(1'b1, 3'h0, 9'h1f8);
        rd(1'b0, 3'h0, 9'h133);
        i_prog.stp;
        adr(9'h000, 9'h1fe);
        rd(1'b1, 3'h0, 9'h148);
        rd(1'b0, 3'h0, 9'h17e);
        i_prog.gnt(1'b1);
        i_prog.enter(2'h0);
        chk("mode", {7'h0, `EPV_MODE_NONE}, {7'h0, mode});
        i_prog.gnt(1'b0);
        i_prog.enter(2'h3);
        i_prog.stp;
        chk("mode", {7'h0, `EPV_MODE_NONE}, {7'h0, mode});
        adr(9'h000, 9'h1ff);
        end_sim;
    end
endmodule // epv_port_test
